// [dmlc_pkg.sv]
package dmlc_pkg;
    // ****************************************
    // Index codes
    // ****************************************
    localparam logic [3:0] IDX_CTRL_A = 4'h0;
    localparam logic [3:0] IDX_CTRL_B = 4'h1;
    localparam logic [3:0] IDX_POINTER = 4'h2;
    localparam logic [3:0] IDX_FRAME = 4'h3;
    localparam logic [3:0] IDX_PIXEL = 4'h4;
    localparam logic [3:0] IDX_START = 4'h5;
    localparam logic [3:0] IDX_FLASH_MASK = 4'h6;
    localparam logic [3:0] IDX_FLASH_FIRST = 4'h8;
    localparam logic [3:0] IDX_FLASH_LAST = 4'h9;
    localparam logic [3:0] IDX_CONTRAST = 4'hA;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SLEEP_BIT = 5;
    localparam int PUMP_BIT = 4;
    localparam int GRAPHIC_BIT = 2;
    localparam int DUTY_HI_BIT = 1;
    localparam int DUTY_LO_BIT = 0;
    localparam int DRIVE_BIT = 6;
    localparam int LOWPWR_BIT = 5;
    localparam int AMP_BIT = 4;
    localparam int WOA_BIT = 3;
    localparam int XFIRST_BIT = 1;
    localparam int FLASH_BIT = 0;
    localparam int COL_LSB = 5;
    localparam int COL_W = 3;
    localparam int ROW_W = 5;

    // Bits that exist in each control register
    localparam logic [7:0] CTRL_A_MASK = 8'h37;
    localparam logic [7:0] CTRL_B_MASK = 8'h7B;
    localparam logic [7:0] LINE_MASK = 8'h1F;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] INDEX_RST = 4'h0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] COL_RST = 3'h0;
    localparam logic [4:0] ROW_RST = 5'h00;

    // ****************************************
    // Last valid addresses per duty
    // ****************************************
    localparam logic [2:0] COL_MAX_32 = 3'h4;
    localparam logic [2:0] COL_MAX_16 = 3'h6;
    localparam logic [2:0] COL_MAX_8 = 3'h7;
    localparam logic [4:0] ROW_MAX_32 = 5'h1F;
    localparam logic [4:0] ROW_MAX_16 = 5'h0F;
    localparam logic [4:0] ROW_MAX_8 = 5'h07;
endpackage

// [dmlc_core_if.sv]
`timescale 1ns/1ps
interface dmlc_core_if;
    logic [2:0] col;
    logic [4:0] row;
    logic [2:0] colMax;
    logic [4:0] rowMax;
    logic xFirst;
    logic [2:0] nextCol;
    logic [4:0] nextRow;
    logic memWrite;
    logic [7:0] memWrData;
    logic [7:0] memRdData;
    logic [2:0] scanCol;
    logic [4:0] scanRow;
    logic [7:0] scanData;
    modport ctrl (
        output col, row, colMax, rowMax, xFirst, memWrite, memWrData, scanCol, scanRow,
        input nextCol, nextRow, memRdData, scanData
    );
    modport stepper (
        input col, row, colMax, rowMax, xFirst,
        output nextCol, nextRow
    );
    modport mem (
        input col, row, memWrite, memWrData, scanCol, scanRow,
        output memRdData, scanData
    );
endinterface

// [dmlc_addr_stepper.sv]
`timescale 1ns/1ps
module dmlc_addr_stepper (
    dmlc_core_if.stepper bus
);
    logic colWrap;
    logic rowWrap;

    // ****************************************
    // Auto-increment with wrap and carry
    // ****************************************
    // An address already past the valid area is treated as an overflow too
    always_comb begin
        colWrap = (bus.col >= bus.colMax);
        rowWrap = (bus.row >= bus.rowMax);
        if (bus.xFirst) begin
            bus.nextCol = colWrap ? 3'h0 : bus.col + 3'h1;
            bus.nextRow = colWrap ? (rowWrap ? 5'h00 : bus.row + 5'h01) : bus.row;
        end else begin
            bus.nextRow = rowWrap ? 5'h00 : bus.row + 5'h01;
            bus.nextCol = rowWrap ? (colWrap ? 3'h0 : bus.col + 3'h1) : bus.col;
        end
    end
endmodule

// [dmlc_pixel_mem.sv]
`timescale 1ns/1ps
module dmlc_pixel_mem (
    input wire logic clk,
    dmlc_core_if.mem bus
);
    // ****************************************
    // Display memory, 8 columns by 32 rows
    // ****************************************
    // No reset: contents are undefined until software clears them
    logic [7:0] cells [0:255];

    always_ff @(posedge clk) begin
        if (bus.memWrite) begin
            cells[{bus.col, bus.row}] <= bus.memWrData;
        end
    end

    assign bus.memRdData = cells[{bus.col, bus.row}];
    assign bus.scanData = cells[{bus.scanCol, bus.scanRow}];
endmodule

// [dmlc_ctrl_top.sv]
`timescale 1ns/1ps
module dmlc_ctrl_top (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic portSelectLine,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostWrData,
    output logic [7:0] hostRdData,
    input wire logic [2:0] scanCol,
    input wire logic [4:0] scanRow,
    input wire logic blinkPhase,
    output logic [7:0] segData,
    output logic chargePumpOn,
    output logic internalRun,
    output logic panelDriveOn,
    output logic lcdForceGround,
    output logic bufferAmpOn,
    output logic ampHighZ,
    output logic ampLowPower
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rstSync1;
    logic rstSync2;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0] indexCode;
        logic [7:0] ctrlA;
        logic [7:0] ctrlB;
        logic [2:0] colAddr;
        logic [4:0] rowAddr;
        logic [7:0] flashMask;
        logic [4:0] flashFirst;
        logic [4:0] flashLast;
        logic [7:0] rdData;
        logic [7:0] seg;
        logic pumpOut;
        logic runOut;
        logic driveOut;
        logic groundOut;
        logic ampOut;
        logic hizOut;
        logic lowPwrOut;
    } dmlc_state_t;

    dmlc_state_t state_reg;
    dmlc_state_t state_next;

    dmlc_core_if core ();

    dmlc_addr_stepper u_stepper (
        .bus(core.stepper)
    );

    dmlc_pixel_mem u_mem (
        .clk(sys_clk),
        .bus(core.mem)
    );

    // ****************************************
    // Decoded modes
    // ****************************************
    logic graphic;
    logic duty8;
    logic duty16;
    logic [2:0] colMax;
    logic [4:0] rowMax;
    logic dataWrite;
    logic dataRead;
    logic stepNow;
    logic rdTaken;
    logic scanValid;
    logic blinkHit;
    logic [7:0] shownData;
    logic [7:0] regRdData;

    always_comb begin
        graphic = state_reg.ctrlA[dmlc_pkg::GRAPHIC_BIT];
        duty8 = state_reg.ctrlA[dmlc_pkg::DUTY_HI_BIT];
        duty16 = !duty8 && state_reg.ctrlA[dmlc_pkg::DUTY_LO_BIT];
        if (duty8) begin
            rowMax = dmlc_pkg::ROW_MAX_8;
        end else if (duty16) begin
            rowMax = dmlc_pkg::ROW_MAX_16;
        end else begin
            rowMax = dmlc_pkg::ROW_MAX_32;
        end
        // Character mode keeps all eight columns usable
        if (!graphic || duty8) begin
            colMax = dmlc_pkg::COL_MAX_8;
        end else if (duty16) begin
            colMax = dmlc_pkg::COL_MAX_16;
        end else begin
            colMax = dmlc_pkg::COL_MAX_32;
        end
    end

    // ****************************************
    // Access decode
    // ****************************************
    // A write in the same cycle as a read wins; the read is dropped
    assign rdTaken = !hostWrite && hostRead;
    assign dataWrite = hostWrite && portSelectLine &&
        (state_reg.indexCode == dmlc_pkg::IDX_PIXEL);
    assign dataRead = rdTaken && portSelectLine &&
        (state_reg.indexCode == dmlc_pkg::IDX_PIXEL);
    assign stepNow = dataWrite || (dataRead && !state_reg.ctrlB[dmlc_pkg::WOA_BIT]);

    // ****************************************
    // Core connections
    // ****************************************

    assign core.col = state_reg.colAddr;
    assign core.row = state_reg.rowAddr;
    assign core.colMax = colMax;
    assign core.rowMax = rowMax;
    assign core.xFirst = state_reg.ctrlB[dmlc_pkg::XFIRST_BIT];
    assign core.memWrite = dataWrite;
    assign core.memWrData = hostWrData;
    assign core.scanCol = scanCol;
    assign core.scanRow = scanRow;

    // ****************************************
    // Segment data path
    // ****************************************
    always_comb begin
        scanValid = (scanCol <= colMax) && (scanRow <= rowMax);
        blinkHit = state_reg.ctrlB[dmlc_pkg::FLASH_BIT] && state_reg.ctrlB[dmlc_pkg::DRIVE_BIT] &&
            blinkPhase && state_reg.flashMask[scanCol] &&
            (scanRow >= state_reg.flashFirst) && (scanRow <= state_reg.flashLast);
        if (graphic) begin
            shownData = core.scanData;
        end else begin
            shownData = {3'h0, core.scanData[4:0]};
        end
        if (!state_reg.ctrlB[dmlc_pkg::DRIVE_BIT] || !scanValid || blinkHit) begin
            shownData = 8'h00;
        end
    end

    // ****************************************
    // Register read mux
    // ****************************************
    // Unmapped codes, including the start and contrast codes, read as zero
    always_comb begin
        regRdData = 8'h00;
        if (!portSelectLine) begin
            regRdData = {4'h0, state_reg.indexCode};
        end else begin
            unique case (state_reg.indexCode)
                dmlc_pkg::IDX_CTRL_A: begin
                    regRdData = state_reg.ctrlA;
                end
                dmlc_pkg::IDX_CTRL_B: begin
                    regRdData = state_reg.ctrlB;
                end
                dmlc_pkg::IDX_POINTER: begin
                    regRdData = {state_reg.colAddr, state_reg.rowAddr};
                end
                dmlc_pkg::IDX_PIXEL: begin
                    regRdData = core.memRdData;
                end
                dmlc_pkg::IDX_FLASH_MASK: begin
                    regRdData = state_reg.flashMask;
                end
                dmlc_pkg::IDX_FLASH_FIRST: begin
                    regRdData = {3'h0, state_reg.flashFirst};
                end
                dmlc_pkg::IDX_FLASH_LAST: begin
                    regRdData = {3'h0, state_reg.flashLast};
                end
                default: begin
                    regRdData = 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        if (hostWrite) begin
            if (!portSelectLine) begin
                state_next.indexCode = hostWrData[3:0];
            end else begin
                unique case (state_reg.indexCode)
                    dmlc_pkg::IDX_CTRL_A: begin
                        state_next.ctrlA = hostWrData & dmlc_pkg::CTRL_A_MASK;
                    end
                    dmlc_pkg::IDX_CTRL_B: begin
                        state_next.ctrlB = hostWrData & dmlc_pkg::CTRL_B_MASK;
                    end
                    dmlc_pkg::IDX_POINTER: begin
                        state_next.colAddr = hostWrData[7:dmlc_pkg::COL_LSB];
                        state_next.rowAddr = hostWrData[dmlc_pkg::ROW_W-1:0];
                    end
                    dmlc_pkg::IDX_FLASH_MASK: begin
                        state_next.flashMask = hostWrData;
                    end
                    dmlc_pkg::IDX_FLASH_FIRST: begin
                        state_next.flashFirst = hostWrData[4:0];
                    end
                    dmlc_pkg::IDX_FLASH_LAST: begin
                        state_next.flashLast = hostWrData[4:0];
                    end
                    default: begin
                    end
                endcase
            end
        end else if (rdTaken) begin
            state_next.rdData = regRdData;
        end
        if (stepNow) begin
            state_next.colAddr = core.nextCol;
            state_next.rowAddr = core.nextRow;
        end
        // Sleep keeps the pump bit but drops panel and amp enables
        if (state_next.ctrlA[dmlc_pkg::SLEEP_BIT]) begin
            state_next.ctrlB[dmlc_pkg::DRIVE_BIT] = 1'b0;
            state_next.ctrlB[dmlc_pkg::AMP_BIT] = 1'b0;
        end
        state_next.runOut = !state_next.ctrlA[dmlc_pkg::SLEEP_BIT];
        state_next.pumpOut = state_next.ctrlA[dmlc_pkg::PUMP_BIT] &&
            !state_next.ctrlA[dmlc_pkg::SLEEP_BIT];
        state_next.driveOut = state_next.ctrlB[dmlc_pkg::DRIVE_BIT];
        state_next.groundOut = !state_next.ctrlB[dmlc_pkg::DRIVE_BIT];
        state_next.ampOut = state_next.ctrlB[dmlc_pkg::AMP_BIT];
        state_next.hizOut = !state_next.ctrlB[dmlc_pkg::AMP_BIT];
        state_next.lowPwrOut = state_next.ctrlB[dmlc_pkg::LOWPWR_BIT] &&
            state_next.ctrlB[dmlc_pkg::AMP_BIT];
        state_next.seg = shownData;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            state_reg.indexCode <= dmlc_pkg::INDEX_RST;
            state_reg.ctrlA <= dmlc_pkg::CTRL_RST;
            state_reg.ctrlB <= dmlc_pkg::CTRL_RST;
            state_reg.colAddr <= dmlc_pkg::COL_RST;
            state_reg.rowAddr <= dmlc_pkg::ROW_RST;
            state_reg.flashMask <= dmlc_pkg::CTRL_RST;
            state_reg.flashFirst <= dmlc_pkg::ROW_RST;
            state_reg.flashLast <= dmlc_pkg::ROW_RST;
            state_reg.rdData <= dmlc_pkg::CTRL_RST;
            state_reg.seg <= dmlc_pkg::CTRL_RST;
            // Outputs start as with the sleep bit clear and every enable off
            state_reg.pumpOut <= 1'b0;
            state_reg.runOut <= 1'b1;
            state_reg.driveOut <= 1'b0;
            state_reg.groundOut <= 1'b1;
            state_reg.ampOut <= 1'b0;
            state_reg.hizOut <= 1'b1;
            state_reg.lowPwrOut <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hostRdData = state_reg.rdData;
    assign segData = state_reg.seg;
    assign chargePumpOn = state_reg.pumpOut;
    assign internalRun = state_reg.runOut;
    assign panelDriveOn = state_reg.driveOut;
    assign lcdForceGround = state_reg.groundOut;
    assign bufferAmpOn = state_reg.ampOut;
    assign ampHighZ = state_reg.hizOut;
    assign ampLowPower = state_reg.lowPwrOut;
endmodule

// [dmlc_host_model.sv]
`timescale 1ns/1ps
module dmlc_host_model (
    input wire logic sys_clk,
    output logic portSelectLine,
    output logic hostWrite,
    output logic hostRead,
    output logic [7:0] hostWrData,
    input wire logic [7:0] hostRdData
);
    // ****************************************
    // Register port cycles
    // ****************************************
    initial begin
        portSelectLine = 1'b0;
        hostWrite = 1'b0;
        hostRead = 1'b0;
        hostWrData = 8'h00;
    end

    // Select low reaches the index, high the indexed register
    task automatic access(input logic sel, input logic wr, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        portSelectLine = sel;
        hostWrite = wr;
        hostRead = !wr;
        hostWrData = d;
        @(posedge sys_clk);
        #1;
        hostWrite = 1'b0;
        hostRead = 1'b0;
        // Stale data is inverted so it never passes for a fresh value
        hostWrData = ~d;
    endtask

    task automatic wr(input logic sel, input logic [7:0] d);
        access(sel, 1'b1, d);
    endtask

    task automatic rd(input logic sel, output logic [7:0] d);
        access(sel, 1'b0, 8'h00);
        @(posedge sys_clk);
        #1;
        d = hostRdData;
    endtask
endmodule

// [dmlc_ctrl_sva.sv]
`timescale 1ns/1ps
module dmlc_ctrl_sva (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic portSelectLine,
    input wire logic hostWrite,
    input wire logic hostRead,
    input wire logic [7:0] hostRdData,
    input wire logic [7:0] segData,
    input wire logic chargePumpOn,
    input wire logic internalRun,
    input wire logic panelDriveOn,
    input wire logic lcdForceGround,
    input wire logic bufferAmpOn,
    input wire logic ampHighZ,
    input wire logic ampLowPower
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_ground;
        lcdForceGround == !panelDriveOn;
    endproperty
    a_ground: assert property (p_ground) else $error("Ground force off panel state");
    property p_hiz;
        ampHighZ == !bufferAmpOn;
    endproperty
    a_hiz: assert property (p_hiz) else $error("Amp high-z off amp state");
    property p_lowpwr;
        ampLowPower |-> bufferAmpOn;
    endproperty
    a_lowpwr: assert property (p_lowpwr) else $error("Low power without amps");
    property p_sleep;
        !internalRun |-> !panelDriveOn && !bufferAmpOn && !chargePumpOn;
    endproperty
    a_sleep: assert property (p_sleep) else $error("Drive left on in sleep");
    property p_blank;
        (!panelDriveOn) [*2] |-> segData == 8'h00;
    endproperty
    a_blank: assert property (p_blank) else $error("Segments driven with panel off");
    property p_rdhold;
        !(hostRead && !hostWrite) |=> $stable(hostRdData);
    endproperty
    a_rdhold: assert property (p_rdhold) else $error("Read data moved without a read");
    property p_idx;
        hostRead && !hostWrite && !portSelectLine |=> hostRdData[7:4] == 4'h0;
    endproperty
    a_idx: assert property (p_idx) else $error("Index read has upper bits set");
    property p_quiet;
        (!hostWrite) [*2] |=> $stable({chargePumpOn, internalRun, panelDriveOn, bufferAmpOn});
    endproperty
    a_quiet: assert property (p_quiet) else $error("Control moved without a write");
endmodule

bind dmlc_ctrl_top dmlc_ctrl_sva u_sva (
    .sys_clk(sys_clk), .nrst(nrst), .portSelectLine(portSelectLine),
    .hostWrite(hostWrite), .hostRead(hostRead), .hostRdData(hostRdData),
    .segData(segData), .chargePumpOn(chargePumpOn), .internalRun(internalRun),
    .panelDriveOn(panelDriveOn), .lcdForceGround(lcdForceGround),
    .bufferAmpOn(bufferAmpOn), .ampHighZ(ampHighZ), .ampLowPower(ampLowPower)
);

// [dmlc_ctrl_tb_top.sv]
`timescale 1ns/1ps
module dmlc_ctrl_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic portSelectLine, hostWrite, hostRead;
    logic [7:0] hostWrData, hostRdData, segData, rd, outs;
    logic [2:0] scanCol = 3'h0;
    logic [4:0] scanRow = 5'h00;
    logic blinkPhase = 1'b0;
    logic chargePumpOn, internalRun, panelDriveOn, lcdForceGround;
    logic bufferAmpOn, ampHighZ, ampLowPower;
    int failures = 0;
    int nCompared = 0;
    int cycles = 0;

    assign outs = {1'b0, chargePumpOn, internalRun, panelDriveOn, lcdForceGround,
                   bufferAmpOn, ampHighZ, ampLowPower};
    always #4 sys_clk = ~sys_clk;

    dmlc_host_model host (.sys_clk(sys_clk), .portSelectLine(portSelectLine),
        .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
        .hostRdData(hostRdData));
    dmlc_ctrl_top dut (.sys_clk(sys_clk), .nrst(nrst), .portSelectLine(portSelectLine),
        .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .scanCol(scanCol), .scanRow(scanRow),
        .blinkPhase(blinkPhase), .segData(segData), .chargePumpOn(chargePumpOn),
        .internalRun(internalRun), .panelDriveOn(panelDriveOn),
        .lcdForceGround(lcdForceGround), .bufferAmpOn(bufferAmpOn),
        .ampHighZ(ampHighZ), .ampLowPower(ampLowPower));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
        host.wr(1'b0, {4'h0, idx});
        host.wr(1'b1, d);
    endtask
    task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        host.wr(1'b0, {4'h0, idx});
        host.rd(1'b1, d);
        chk(d, exp);
    endtask
    task automatic tick();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    // Scan path is registered, so settle two edges before sampling
    task automatic scan(input logic [2:0] c, input logic [4:0] r, input logic ph,
                        input logic [7:0] exp);
        scanCol = c;
        scanRow = r;
        blinkPhase = ph;
        tick();
        chk(segData, exp);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // Hang guard
    // ****************************************
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        tick();
        chk(outs, 8'h2A);
        rchk(dmlc_pkg::IDX_CTRL_A, 8'h00);
        rchk(dmlc_pkg::IDX_CTRL_B, 8'h00);
        rchk(dmlc_pkg::IDX_POINTER, 8'h00);
        wreg(4'h7, 8'h15);
        rchk(4'h7, 8'h00);
        host.rd(1'b0, rd);
        chk(rd, 8'h07);
        wreg(dmlc_pkg::IDX_CTRL_A, 8'h10);
        tick();
        chk(outs, 8'h6A);
        wreg(dmlc_pkg::IDX_CTRL_B, 8'h70);
        tick();
        chk(outs, 8'h75);
        wreg(dmlc_pkg::IDX_CTRL_A, 8'h30);
        tick();
        chk(outs, 8'h0A);
        rchk(dmlc_pkg::IDX_CTRL_A, 8'h30);
        rchk(dmlc_pkg::IDX_CTRL_B, 8'h20);
        // Character mode, 1/32 duty, row first from the last row
        wreg(dmlc_pkg::IDX_CTRL_A, 8'h00);
        wreg(dmlc_pkg::IDX_CTRL_B, 8'h40);
        wreg(dmlc_pkg::IDX_POINTER, 8'h1F);
        wreg(dmlc_pkg::IDX_PIXEL, 8'hAA);
        rchk(dmlc_pkg::IDX_POINTER, 8'h20);
        wreg(dmlc_pkg::IDX_POINTER, 8'h1F);
        rchk(dmlc_pkg::IDX_PIXEL, 8'hAA);
        rchk(dmlc_pkg::IDX_POINTER, 8'h20);
        scan(3'h0, 5'h1F, 1'b0, 8'h0A);
        wreg(dmlc_pkg::IDX_CTRL_A, 8'h04);
        scan(3'h0, 5'h1F, 1'b0, 8'hAA);
        scan(3'h5, 5'h1F, 1'b0, 8'h00);
        // Blink window over column 0, rows 30 to 31
        wreg(dmlc_pkg::IDX_CTRL_B, 8'h41);
        wreg(dmlc_pkg::IDX_FLASH_MASK, 8'h01);
        wreg(dmlc_pkg::IDX_FLASH_FIRST, 8'h1E);
        wreg(dmlc_pkg::IDX_FLASH_LAST, 8'h1F);
        scan(3'h0, 5'h1F, 1'b1, 8'h00);
        scan(3'h0, 5'h1F, 1'b0, 8'hAA);
        // Graphic 1/16, column first from the last valid column
        wreg(dmlc_pkg::IDX_CTRL_B, 8'h42);
        wreg(dmlc_pkg::IDX_CTRL_A, 8'h05);
        wreg(dmlc_pkg::IDX_POINTER, 8'hC3);
        wreg(dmlc_pkg::IDX_PIXEL, 8'h11);
        rchk(dmlc_pkg::IDX_POINTER, 8'h04);
        scan(3'h6, 5'h03, 1'b0, 8'h11);
        scan(3'h0, 5'h10, 1'b0, 8'h00);
        // Write-only advance at 1/8 duty
        wreg(dmlc_pkg::IDX_CTRL_B, 8'h48);
        wreg(dmlc_pkg::IDX_CTRL_A, 8'h02);
        wreg(dmlc_pkg::IDX_POINTER, 8'h07);
        wreg(dmlc_pkg::IDX_PIXEL, 8'h04);
        rchk(dmlc_pkg::IDX_POINTER, 8'h20);
        wreg(dmlc_pkg::IDX_POINTER, 8'h07);
        rchk(dmlc_pkg::IDX_PIXEL, 8'h04);
        rchk(dmlc_pkg::IDX_POINTER, 8'h07);
        wreg(dmlc_pkg::IDX_PIXEL, 8'h33);
        rchk(dmlc_pkg::IDX_POINTER, 8'h20);
        // Duty code 11 is also 1/8: row 7 shows, row 8 is blank
        wreg(dmlc_pkg::IDX_CTRL_A, 8'h03);
        scan(3'h0, 5'h07, 1'b0, 8'h13);
        scan(3'h0, 5'h08, 1'b0, 8'h00);
        end_of_test();
    end
endmodule
